// >>> core/link_sync.sv
// link_sync: two-flop synchronisers for the serial pins.
// assumes: pins are asynchronous to ref_clk; nothing reads stage one but stage two.
`timescale 1ns/10ps
module link_sync (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [spi_host_pkg::SYNC_W-1:0] din,
   output logic [spi_host_pkg::SYNC_W-1:0] dout
);
   import spi_host_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
   } sync_t;

   sync_t q;
   sync_t next_q;

   // shift the pins through both stages
   always_comb begin
      next_q.s1 = din;
      next_q.s2 = q.s1;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= '{s1: SYNC_RESET, s2: SYNC_RESET};
      end else begin
         q <= next_q;
      end
   end

   assign dout = q.s2;
endmodule

// >>> core/reader_spi_host_port.sv
// reader_spi_host_port: serial host port of the reader, pin side to register side.
// assumes: register file decodes reg_addr combinationally into exists, writable
// and rdata; long commands report their end on cmd_done; ref_clk is 200 MHz.
//
// How it works
// - port acts only while select is low; host keeps select high otherwise
// - each input bit is captured at a falling serial clock edge
// - whole bytes only, most significant bit first both ways
// - top two bits of the first byte: write, read, command, reserved
// - low six bits hold register address or command id, bit 5 highest
// - address steps by one after every data byte of a burst
// - a data byte cut short by select rising is dropped unwritten
// - writes to missing or read-only registers have no effect
// - read bits leave on rising serial clock, host samples on falling
// - reads of missing registers return all zero bytes
// - output line is driven only while read data shifts out
// - pull-down on idle output line when both pull-down bits are set
// - commands are single bytes; query parameters arrive as buffer writes
// - a command starts at the last falling edge of its byte
// - a finished command raises the interrupt request
// - conversion, calibration, supply and oscillator commands run long
// - only the supported command codes from 80h to abh are decoded
// - interrupt request and host clock outputs are driven
// - soft init restores defaults and aborts running functions
// - an immediate command may be followed by read or write in one frame
`timescale 1ns/10ps
module reader_spi_host_port (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic serial_select_low,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso_out,
   output logic miso_oe,
   output logic miso_pd_en,
   input wire logic out_line_pulldown_a,
   input wire logic out_line_pulldown_b,
   output logic [5:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_exists,
   input wire logic reg_writable,
   output logic [7:0] cmd_code,
   output logic cmd_start,
   output logic cmd_long,
   output logic soft_init,
   input wire logic cmd_done,
   input wire logic irq_ack,
   output logic irq,
   output logic host_clock_out
);
   import spi_host_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      phase_t phase;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] tx;
      logic step;
      logic sclk_prev;
      logic miso_out;
      logic miso_oe;
      logic pd_en;
      logic [5:0] reg_addr;
      logic [7:0] reg_wdata;
      logic reg_wr;
      logic reg_rd;
      logic [7:0] cmd_code;
      logic cmd_start;
      logic cmd_long;
      logic soft_init;
      logic busy;
      logic irq;
      logic [3:0] div_cnt;
      logic host_clk;
   } state_t;

   state_t q;
   state_t next_q;

   logic [SYNC_W-1:0] pins_s;
   logic selected;
   logic sclk_s;
   logic mosi_s;
   logic fall;
   logic rise;
   logic byte_end;
   logic [7:0] byte_in;
   logic cmd_ok;
   logic cmd_is_long;

   // pins cross into ref_clk through two flops
   link_sync u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .din({serial_select_low, sclk, mosi}),
      .dout(pins_s)
   );

   // ------------------------------------------------------------
   // edge finding and byte decode helpers
   // ------------------------------------------------------------
   assign selected = ~pins_s[SYNC_SEL];
   assign sclk_s = pins_s[SYNC_SCLK];
   assign mosi_s = pins_s[SYNC_MOSI];
   assign fall = q.sclk_prev & ~sclk_s;
   assign rise = ~q.sclk_prev & sclk_s;
   assign byte_end = selected & fall & (q.bit_cnt == BIT_LAST);
   assign byte_in = {q.shift[6:0], mosi_s};
   assign cmd_ok = CMD_SUPPORTED[byte_in[5:0]];
   assign cmd_is_long = ({OP_CMD, byte_in[5:0]} == CMD_AD_CONV) ||
                        ({OP_CMD, byte_in[5:0]} == CMD_RX_CAL) ||
                        ({OP_CMD, byte_in[5:0]} == CMD_AUTO_SUPPLY) ||
                        ({OP_CMD, byte_in[5:0]} == CMD_AUTO_OSC);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.reg_wr = 1'b0;
      next_q.reg_rd = 1'b0;
      next_q.cmd_start = 1'b0;
      next_q.soft_init = 1'b0;
      next_q.step = 1'b0;
      next_q.sclk_prev = sclk_s;

      // host clock divider
      if (q.div_cnt == HOST_CLK_HALF - 4'h1) begin
         next_q.div_cnt = 4'h0;
         next_q.host_clk = ~q.host_clk;
      end else begin
         next_q.div_cnt = q.div_cnt + 4'h1;
      end

      // long command end; software clear first so a new set wins
      if (irq_ack) begin
         next_q.irq = 1'b0;
      end
      if (cmd_done && q.busy) begin
         next_q.busy = 1'b0;
         next_q.irq = 1'b1;
      end

      // burst address advances one cycle after the byte's strobe
      if (q.step) begin
         next_q.reg_addr = q.reg_addr + ADDR_STEP;
         next_q.reg_rd = (q.phase == PH_READ);
      end

      if (!selected) begin
         // idle frame: counters cleared, line released
         next_q.phase = PH_OP;
         next_q.bit_cnt = 3'h0;
         next_q.miso_oe = 1'b0;
      end else begin
         // register data arrives with the read strobe
         if (q.reg_rd) begin
            next_q.tx = reg_exists ? reg_rdata : 8'h00;
         end
         // read bit goes out on a rising serial clock
         if (rise && q.phase == PH_READ) begin
            next_q.miso_out = q.tx[7];
            next_q.tx = {q.tx[6:0], 1'b0};
            next_q.miso_oe = 1'b1;
         end
         if (fall) begin
            next_q.shift = byte_in;
            next_q.bit_cnt = q.bit_cnt + 3'h1;
         end
         if (byte_end) begin
            unique case (q.phase)
               PH_OP: begin
                  unique case (byte_in[7:6])
                     OP_WRITE: begin
                        next_q.phase = PH_WRITE;
                        next_q.reg_addr = byte_in[5:0];
                     end
                     OP_READ: begin
                        next_q.phase = PH_READ;
                        next_q.reg_addr = byte_in[5:0];
                        next_q.reg_rd = 1'b1;
                     end
                     OP_CMD: begin
                        if (cmd_ok) begin
                           // query needs no extra bytes here: its buffer fill is a write
                           next_q.cmd_start = 1'b1;
                           next_q.cmd_code = {OP_CMD, byte_in[5:0]};
                           next_q.cmd_long = cmd_is_long;
                           if (cmd_is_long) begin
                              next_q.busy = 1'b1;
                           end else begin
                              next_q.irq = 1'b1;
                           end
                           if ({OP_CMD, byte_in[5:0]} == CMD_SOFT_INIT) begin
                              next_q.soft_init = 1'b1;
                              next_q.busy = 1'b0;
                           end
                           // stays in PH_OP so a read or write may follow
                           next_q.phase = PH_OP;
                        end else begin
                           next_q.phase = PH_IGNORE;
                        end
                     end
                     OP_RESERVED: begin
                        next_q.phase = PH_IGNORE;
                     end
                  endcase
               end
               PH_WRITE: begin
                  // only a whole byte reaches here
                  next_q.reg_wr = reg_exists & reg_writable;
                  next_q.reg_wdata = byte_in;
                  next_q.step = 1'b1;
               end
               PH_READ: begin
                  next_q.step = 1'b1;
               end
               PH_IGNORE: begin
                  next_q.phase = PH_IGNORE;
               end
            endcase
         end
      end

      // pull-down only while the line is released
      next_q.pd_en = out_line_pulldown_a & out_line_pulldown_b & ~next_q.miso_oe;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= '{phase: PH_OP, bit_cnt: 3'h0, shift: 8'h00, tx: 8'h00, step: 1'b0,
                sclk_prev: 1'b0, miso_out: 1'b0, miso_oe: 1'b0, pd_en: 1'b0,
                reg_addr: ADDR_RESET, reg_wdata: 8'h00, reg_wr: 1'b0, reg_rd: 1'b0,
                cmd_code: CMD_RESET, cmd_start: 1'b0, cmd_long: 1'b0, soft_init: 1'b0,
                busy: 1'b0, irq: 1'b0, div_cnt: 4'h0, host_clk: 1'b0};
      end else begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // outputs, all from flops
   // ------------------------------------------------------------
   assign miso_out = q.miso_out;
   assign miso_oe = q.miso_oe;
   assign miso_pd_en = q.pd_en;
   assign reg_addr = q.reg_addr;
   assign reg_wdata = q.reg_wdata;
   assign reg_wr = q.reg_wr;
   assign reg_rd = q.reg_rd;
   assign cmd_code = q.cmd_code;
   assign cmd_start = q.cmd_start;
   assign cmd_long = q.cmd_long;
   assign soft_init = q.soft_init;
   assign irq = q.irq;
   assign host_clock_out = q.host_clk;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence s_byte_end;
      byte_end;
   endsequence

   sequence s_op_byte(logic [1:0] op);
      s_byte_end ##0 (q.phase == PH_OP && byte_in[7:6] == op);
   endsequence

   sequence s_rise_read;
      selected && rise && q.phase == PH_READ;
   endsequence

   a_select_idle: assert property (
      !selected |=> (!q.miso_oe && q.bit_cnt == 3'h0 && q.phase == PH_OP))
      else $error("port not idle after select high");

   a_sample_fall: assert property (
      selected && fall |=> q.shift[0] == $past(mosi_s))
      else $error("input bit not taken at falling edge");

   a_msb_first: assert property (
      selected && fall |=> q.shift[7:1] == $past(q.shift[6:0]))
      else $error("shift order not msb first");

   a_op_write: assert property (
      s_op_byte(OP_WRITE) |=> (q.phase == PH_WRITE && q.reg_addr == $past(byte_in[5:0])))
      else $error("write operation not decoded");

   a_op_read: assert property (
      s_op_byte(OP_READ) |=> (q.phase == PH_READ && q.reg_rd && q.reg_addr == $past(byte_in[5:0])))
      else $error("read address not taken");

   a_addr_step: assert property (
      q.step |=> q.reg_addr == $past(q.reg_addr) + ADDR_STEP)
      else $error("burst address did not step");

   a_write_whole: assert property (
      q.reg_wr |-> $past(byte_end && q.phase == PH_WRITE))
      else $error("write strobe without a whole byte");

   a_write_guard: assert property (
      s_byte_end ##0 (q.phase == PH_WRITE && !(reg_exists && reg_writable)) |=> !q.reg_wr)
      else $error("write to missing or read-only register");

   a_read_shift: assert property (
      s_rise_read |=> (q.miso_oe && q.miso_out == $past(q.tx[7])))
      else $error("read bit not shifted on rising edge");

   a_read_zero: assert property (
      selected && q.reg_rd && !reg_exists && !rise |=> q.tx == 8'h00)
      else $error("missing register did not read zero");

   a_oe_only_read: assert property (
      q.miso_oe |-> q.phase == PH_READ)
      else $error("output driven outside read data");

   a_pulldown: assert property (
      q.pd_en |-> !q.miso_oe ##1 (q.pd_en || !$past(out_line_pulldown_a && out_line_pulldown_b)
                                  || q.miso_oe))
      else $error("pull-down with line driven");

   a_cmd_start: assert property (
      s_op_byte(OP_CMD) ##0 cmd_ok |=> (q.cmd_start && q.phase == PH_OP))
      else $error("supported command not started");

   a_cmd_irq: assert property (
      q.cmd_start && !q.cmd_long |-> q.irq)
      else $error("immediate command raised no interrupt");

   a_long_busy: assert property (
      q.cmd_start && q.cmd_long |-> (q.busy && q.cmd_code[7:6] == OP_CMD))
      else $error("long command not marked running");

   a_soft_init: assert property (
      q.soft_init |-> (!q.busy && q.cmd_code == CMD_SOFT_INIT))
      else $error("soft init did not abort");

   a_bad_op: assert property (
      s_op_byte(OP_RESERVED) |=> (q.phase == PH_IGNORE && !q.cmd_start)[*2])
      else $error("reserved operation not ignored");

endmodule

// >>> core/spi_host_pkg.sv
// spi_host_pkg: constants and types of the reader's serial host port.
// assumes: shared by the port top and its input synchroniser; no clock of its own.
package spi_host_pkg;

   // ------------------------------------------------------------
   // synchroniser layout {select_low, sclk, mosi}
   // ------------------------------------------------------------
   localparam int SYNC_W = 3;
   localparam logic [2:0] SYNC_RESET = 3'h4;   // select reads idle-high at reset
   localparam int SYNC_SEL = 2;
   localparam int SYNC_SCLK = 1;
   localparam int SYNC_MOSI = 0;

   // ------------------------------------------------------------
   // byte framing and operation field of the first byte
   // ------------------------------------------------------------
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_CMD = 2'h2;
   localparam logic [1:0] OP_RESERVED = 2'h3;
   localparam logic [5:0] ADDR_RESET = 6'h00;
   localparam logic [5:0] ADDR_STEP = 6'h01;

   // ------------------------------------------------------------
   // direct commands
   // ------------------------------------------------------------
   // one bit per command id (low six bits of the code), set = supported
   localparam logic [63:0] CMD_SUPPORTED = 64'h0000_0ffc_bfc7_07bb;
   localparam logic [7:0] CMD_SOFT_INIT = 8'h83;
   localparam logic [7:0] CMD_AD_CONV = 8'h87;
   localparam logic [7:0] CMD_RX_CAL = 8'h88;
   localparam logic [7:0] CMD_QUERY = 8'h98;
   localparam logic [7:0] CMD_AUTO_SUPPLY = 8'ha2;
   localparam logic [7:0] CMD_AUTO_OSC = 8'ha4;
   localparam logic [7:0] CMD_RESET = 8'h80;

   // ------------------------------------------------------------
   // host clock output: ref_clk divided by twice this half period
   // ------------------------------------------------------------
   localparam logic [3:0] HOST_CLK_HALF = 4'h2;

   typedef enum logic [1:0] {PH_OP, PH_WRITE, PH_READ, PH_IGNORE} phase_t;

endpackage

// >>> tb/host_model.sv
// host_model: serial bus master standing in for the host controller.
// assumes: clk is the bench's ref_clk and only paces the serial pins.
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   input wire logic miso_line,
   output logic serial_select_low,
   output logic sclk,
   output logic mosi
);
   localparam int HALF = 16; // 80 ns half period
   // ------------------------------------------------------------
   // idle pins: select high, serial clock parked low
   // ------------------------------------------------------------
   initial begin
      serial_select_low = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // half a serial period, paced on falling clock edges
   task automatic half();
      repeat (HALF) @(negedge clk);
   endtask
   // select low opens a frame
   task automatic open_frame();
      half();
      serial_select_low = 1'b0;
      half();
   endtask
   // select high; data line flipped so no stale level lingers
   task automatic close_frame();
      half();
      serial_select_low = 1'b1;
      mosi = ~mosi;
      half();
      half();
   endtask
   // n bits of d, msb first; drive on rise, sample on fall
   task automatic shift(input int n, input logic [7:0] d, output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         half();
         sclk = 1'b1;
         mosi = d[i];
         half();
         sclk = 1'b0;
         r[i] = miso_line;
      end
   endtask
endmodule

// >>> tb/reader_spi_host_port_tb.sv
// reader_spi_host_port_tb: self-checking bench of the serial host port.
// assumes: host_model drives the pins; bench models register file and command side.
`timescale 1ns/10ps
module reader_spi_host_port_tb;
   import spi_host_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic serial_select_low, sclk, mosi, miso_line, last_miso = 1'b0, long_seen = 1'b0;
   logic miso_out, miso_oe, miso_pd_en, pd_a = 1'b0, pd_b = 1'b0;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, cmd_code, reg_rdata;
   logic reg_wr, reg_rd, reg_exists, cmd_start, cmd_long, soft_init, irq, host_clock_out;
   logic reg_writable;
   logic cmd_done = 1'b0, irq_ack = 1'b0;
   logic [7:0] regs [64];
   logic [7:0] shadow [64];
   logic [31:0] seed = 32'h42fd;
   int num_errors = 0, checked = 0, n_wr = 0, n_start = 0, n_init = 0, n_rd = 0;

   always #2.5 ref_clk = ~ref_clk;
   // ------------------------------------------------------------
   // register file: 00h-2fh exist, 00h-1fh writable
   // ------------------------------------------------------------
   function automatic logic ex(input logic [5:0] a);
      return a < 6'h30;
   endfunction
   function automatic logic wr_ok(input logic [5:0] a);
      return a < 6'h20;
   endfunction
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   assign reg_rdata = regs[reg_addr];
   assign reg_exists = ex(reg_addr);
   assign reg_writable = wr_ok(reg_addr);
   // line level: driven, pulled down, or inverse of last bit when floating
   assign miso_line = miso_oe ? miso_out : (miso_pd_en ? 1'b0 : ~last_miso);

   host_model host (.clk(ref_clk), .miso_line(miso_line),
      .serial_select_low(serial_select_low), .sclk(sclk), .mosi(mosi));
   reader_spi_host_port dut (.ref_clk(ref_clk), .srst(srst),
      .serial_select_low(serial_select_low), .sclk(sclk), .mosi(mosi),
      .miso_out(miso_out), .miso_oe(miso_oe), .miso_pd_en(miso_pd_en),
      .out_line_pulldown_a(pd_a), .out_line_pulldown_b(pd_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_exists(reg_exists), .reg_writable(reg_writable), .cmd_code(cmd_code),
      .cmd_start(cmd_start), .cmd_long(cmd_long), .soft_init(soft_init),
      .cmd_done(cmd_done), .irq_ack(irq_ack), .irq(irq), .host_clock_out(host_clock_out));

   // monitor of strobes and the register store
   always @(posedge ref_clk) begin
      if (miso_oe) last_miso <= miso_out;
      if (cmd_start) begin
         n_start++;
         long_seen <= cmd_long;
      end
      if (soft_init) n_init++;
      if (reg_rd) n_rd++;
      if (reg_wr) begin
         n_wr++;
         regs[reg_addr] <= reg_wdata;
      end
   end
   // ------------------------------------------------------------
   // comparison and closing
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic pulse(input logic done);
      @(negedge ref_clk);
      if (done) cmd_done = 1'b1;
      else irq_ack = 1'b1;
      @(negedge ref_clk);
      cmd_done = 1'b0;
      irq_ack = 1'b0;
      @(negedge ref_clk);
   endtask
   // ------------------------------------------------------------
   // transfers
   // ------------------------------------------------------------
   task automatic write_burst(input logic [5:0] a, input int n, input int part);
      logic [7:0] d, r;
      logic [5:0] p;
      int w0;
      p = a;
      w0 = n_wr;
      host.open_frame();
      host.shift(8, {OP_WRITE, a}, r);
      for (int i = 0; i < n; i++) begin
         d = 8'(rnd());
         host.shift(8, d, r);
         if (wr_ok(p)) begin
            shadow[p] = d;
            w0++;
         end
         p++;
      end
      if (part > 0) host.shift(part, 8'(rnd()), r);
      host.close_frame();
      chk("write_strobes", w0, n_wr);
   endtask
   task automatic read_burst(input logic [5:0] a, input int n);
      logic [7:0] r;
      logic [5:0] p;
      int r0;
      p = a;
      r0 = n_rd;
      host.open_frame();
      host.shift(8, {OP_READ, a}, r);
      for (int i = 0; i < n; i++) begin
         host.shift(8, 8'(rnd()), r);
         chk("read_data", ex(p) ? shadow[p] : 8'h00, r);
         p++;
      end
      host.close_frame();
      chk("miso_released", 1'b0, miso_oe);
      // one fetch for the address byte, one ahead after every data byte
      chk("read_strobes", r0 + n + 1, n_rd);
   endtask
   // mode 1 chains a read, mode 2 leaves a long command running
   task automatic command(input logic [5:0] id, input int mode);
      logic [7:0] r;
      logic sup, lng;
      int s0, i0;
      sup = CMD_SUPPORTED[id];
      lng = (id == 6'h07 || id == 6'h08 || id == 6'h22 || id == 6'h24);
      s0 = n_start;
      i0 = n_init;
      host.open_frame();
      host.shift(8, {OP_CMD, id}, r);
      if (mode == 1) begin
         host.shift(8, {OP_READ, 6'h05}, r);
         host.shift(8, 8'h5a, r);
         chk("chained_read", shadow[5], r);
      end
      host.close_frame();
      chk("cmd_started", s0 + sup, n_start);
      if (sup) chk("cmd_code", {2'b10, id}, cmd_code);
      if (sup) chk("cmd_long", lng, long_seen);
      chk("soft_init", i0 + (sup && id == 6'h03), n_init);
      chk("irq_at_end", sup && !lng, irq);
      if (mode == 2) return;
      if (lng) pulse(1'b1);
      if (lng) chk("irq_long_done", 1'b1, irq);
      pulse(1'b0);
      chk("irq_acked", 1'b0, irq);
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (80000) @(posedge ref_clk);
      num_errors++;
      stop_test();
   end
   initial begin
      logic [31:0] v;
      int cnt;
      logic [7:0] r;
      for (int i = 0; i < 64; i++) begin
         regs[i] = 8'(rnd());
         shadow[i] = regs[i];
      end
      repeat (8) @(negedge ref_clk);
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("cmd_code_reset", CMD_RESET, cmd_code);
      chk("irq_reset", 1'b0, irq);
      for (int k = 0; k < 4; k++) begin
         pd_a = k[0];
         pd_b = k[1];
         repeat (2) @(negedge ref_clk);
         chk("pulldown", k == 3, miso_pd_en);
      end
      cnt = 0;
      for (int i = 0; i < 40; i++) begin
         v[0] = host_clock_out;
         @(negedge ref_clk);
         if (host_clock_out !== v[0]) cnt++;
      end
      chk("host_clock_edges", 40 / HOST_CLK_HALF, cnt);
      write_burst(6'h1c, 6, 0);
      write_burst(6'h3e, 3, 0);
      for (int i = 0; i < 5; i++) begin
         v = rnd();
         write_burst(v[5:0], 1 + v[9:8], v[12:10]);
      end
      read_burst(6'h00, 12);
      read_burst(6'h1a, 10);
      read_burst(6'h2e, 4);
      read_burst(6'h3e, 3);
      // serial clock running with select high must leave the port idle
      cnt = n_wr + n_start;
      host.shift(8, {OP_WRITE, 6'h01}, r);
      host.shift(8, 8'ha5, r);
      repeat (40) @(negedge ref_clk);
      chk("select_high_idle", cnt, n_wr + n_start);
      v = rnd();
      host.open_frame();
      host.shift(8, {OP_RESERVED, v[5:0]}, r);
      host.shift(8, v[15:8], r);
      host.close_frame();
      chk("reserved_ignored", cnt, n_wr + n_start + irq);
      for (int id = 0; id < 64; id++) command(id[5:0], id == 0);
      command(6'h07, 2);
      command(6'h03, 0);
      pulse(1'b1);
      chk("irq_after_abort", 1'b0, irq);
      stop_test();
   end
endmodule
